/* File: src/fss_pkg.sv */
// package for the fail-safe supply supervisor: constants, states and helpers
package fss_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 100_000_000;
	localparam int RST_PULSE_US = 1000;
	localparam int WD_PERIOD_MS = 256;
	localparam int BUS_IDLE_MS = 8000;
	localparam int WD_FAIL_LIMIT = 8;
	localparam longint RST_PULSE_CYC_L = (longint'(CLK_HZ) * RST_PULSE_US) / 1_000_000;
	localparam longint WD_PERIOD_CYC_L = (longint'(CLK_HZ) * WD_PERIOD_MS) / 1000;
	localparam longint BUS_IDLE_CYC_L = (longint'(CLK_HZ) * BUS_IDLE_MS) / 1000;

	// ----------------------------------------------------------------
	// safe mode codes and spi command words
	// ----------------------------------------------------------------
	localparam logic [2:0] SAFE_CODE_A = 3'h7;
	localparam logic [2:0] SAFE_CODE_B1 = 3'h6;
	localparam logic [2:0] SAFE_CODE_B2 = 3'h5;
	localparam logic [2:0] SAFE_CODE_B3 = 3'h4;
	localparam logic [15:0] CMD_SAFE_CLR0 = 16'hdd00;
	localparam logic [15:0] CMD_SAFE_CLR1 = 16'hdd80;
	localparam logic [15:0] CMD_WD_READ = 16'h1b00;
	localparam logic [7:0] CMD_WD_REFRESH = 8'h5a;
	localparam logic [1:0] WD_CNT_W = 2'h0;

	typedef enum logic [1:0] {
		FSS_SAFE_A = 2'h0,
		FSS_SAFE_B1 = 2'h1,
		FSS_SAFE_B2 = 2'h2,
		FSS_SAFE_B3 = 2'h3
	} fss_safe_t;

	typedef enum logic [5:0] {
		FSS_INIT_RESET = 6'h01,
		FSS_INIT = 6'h02,
		FSS_RESET = 6'h04,
		FSS_NORMAL_REQ = 6'h08,
		FSS_NORMAL = 6'h10,
		FSS_SAFE = 6'h20
	} fss_state_t;

	// three-bit code to sub-mode; unknown codes fall back to mode a
	function automatic fss_safe_t fss_decode(input logic [2:0] code);
		case (code)
			SAFE_CODE_B1: fss_decode = FSS_SAFE_B1;
			SAFE_CODE_B2: fss_decode = FSS_SAFE_B2;
			SAFE_CODE_B3: fss_decode = FSS_SAFE_B3;
			default: fss_decode = FSS_SAFE_A;
		endcase
	endfunction : fss_decode

endpackage : fss_pkg

/* File: src/fss_supervisor.sv */
// fail-safe supply supervisor: supply hold, watchdog reset pulses and safe state machine
// Function
// R1: hold bit resets to zero; zero keeps supply on until undervoltage reset.
// R2: hold clear, in reset mode, battery below turn-on: supply off.
// R3: hold set keeps supply on until power-on reset sets battery fail.
// R4: spi code 111 a, 110 b1, 101 b2, 100 b3 overrides resistor.
// R5: resistor selection sampled leaving init; used unless spi override written.
// R6: mode a keeps supply on until failure recovers.
// R7: mode b1 turns supply off after eight seconds bus idle.
// R8: mode b2 turns supply off on low second input pin.
// R9: mode b3 needs both bus idle timeout and low input pin.
// R10: wake-up with supply off enters reset; pin wake needs prior enable.
// R11: wake sources are can, lin, or high input pin when enabled.
// R12: safe output stays low until host clears flags with dd00 or dd80.
// R13: safe output low while in safe mode.
// R14: watchdog failure asserts safe at first or second reset pulse per bit.
// R15: supply below reset threshold drives safe and reset low together; here safe goes low one cycle after reset.
// R16: reset line held low externally enters safe mode.
// R17: no refresh: 1 ms reset pulse every 256 ms, alternating modes.
// R18: eight consecutive watchdog failures are a distinct fail condition.
// R19: recovery needs reset and supply released plus correct refresh.
// R20: refresh is read of random byte then inverted write-back.
// R21: bus idle timer restarts on can activity.
`timescale 1ns/1ps
module fss_supervisor import fss_pkg::*; #(
	parameter longint RST_PULSE_CYC = RST_PULSE_CYC_L,
	parameter longint WD_PERIOD_CYC = WD_PERIOD_CYC_L,
	parameter longint BUS_IDLE_CYC = BUS_IDLE_CYC_L,
	parameter int CNT_W = 32
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic battery_supply_input_ok_in,
	input wire logic por_in,
	input wire logic vdd_uv_in,
	input wire logic rst_pin_in,
	input wire logic can_activity_in,
	input wire logic lin_activity_in,
	input wire logic gen_input2_in,
	input wire logic [2:0] debug_resistor_pin_in,
	input wire logic spi_valid_in,
	input wire logic [15:0] spi_word_in,
	input wire logic low_supply_hold_in,
	input wire logic hold_write_in,
	input wire logic [2:0] safe_override_in,
	input wire logic override_write_in,
	input wire logic second_pulse_sel_in,
	input wire logic pin_wake_en_in,
	input wire logic init_done_in,
	input wire logic [7:0] random_refresh_byte_in,
	output logic vdd_on_out,
	output logic rstn_out,
	output logic safen_out,
	output logic battery_fail_flag_out,
	output logic [5:0] state_out,
	output logic [1:0] safe_mode_out,
	output logic wd_fail8_out
);

	initial begin
		if (RST_PULSE_CYC < 1 || RST_PULSE_CYC >= WD_PERIOD_CYC || CNT_W < 8 || CNT_W > 63 ||
				WD_PERIOD_CYC >= (longint'(1) << CNT_W) || BUS_IDLE_CYC >= (longint'(1) << CNT_W))
			$error("fss_supervisor: bad timing parameters");
	end

	localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(RST_PULSE_CYC - 1);
	localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(WD_PERIOD_CYC - 1);
	localparam logic [CNT_W-1:0] IDLE_LAST = CNT_W'(BUS_IDLE_CYC - 1);
	localparam logic [3:0] FAIL_LIMIT = 4'(WD_FAIL_LIMIT);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [7:0] sync1_reg;
	logic [7:0] sync2_reg;
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			// idle levels: battery ok, no por, no undervoltage, line high, no activity, input high
			sync1_reg <= 8'h93;
			sync2_reg <= 8'h93;
		end else begin
			sync1_reg <= {gen_input2_in, lin_activity_in, can_activity_in, rst_pin_in,
				vdd_uv_in, por_in, 1'b1, battery_supply_input_ok_in};
			sync2_reg <= sync1_reg;
		end
	end
	logic bat_ok;
	logic por_s;
	logic vdd_uv;
	logic rst_pin;
	logic can_act;
	logic lin_act;
	logic in2;
	assign bat_ok = sync2_reg[0];
	assign por_s = sync2_reg[2];
	assign vdd_uv = sync2_reg[3];
	assign rst_pin = sync2_reg[4];
	assign can_act = sync2_reg[5];
	assign lin_act = sync2_reg[6];
	assign in2 = sync2_reg[7];

	// ----------------------------------------------------------------
	// configuration
	// ----------------------------------------------------------------
	fss_state_t state_reg;
	logic hold_reg;
	logic ovr_seen_reg;
	fss_safe_t safe_mode_reg;
	logic pin_wake_reg;
	logic leave_init;
	assign leave_init = (state_reg == FSS_INIT) && init_done_in;

	// R1 hold resets clear
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in)
			hold_reg <= 1'b0;
		else if (hold_write_in)
			hold_reg <= low_supply_hold_in;
	end

	// R4 spi override wins
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ovr_seen_reg <= 1'b0;
			safe_mode_reg <= FSS_SAFE_A;
		end else if (override_write_in && safe_override_in[2]) begin
			ovr_seen_reg <= 1'b1;
			safe_mode_reg <= fss_decode(safe_override_in);
		// R5 sample resistor
		end else if (leave_init && !ovr_seen_reg) begin
			safe_mode_reg <= fss_decode(debug_resistor_pin_in);
		end
	end

	// R10 pin wake latched before safe
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in)
			pin_wake_reg <= 1'b0;
		else if (state_reg != FSS_SAFE)
			pin_wake_reg <= pin_wake_en_in;
	end

	// ----------------------------------------------------------------
	// watchdog refresh and reset pulses
	// ----------------------------------------------------------------
	logic rnd_read_reg;
	logic [7:0] rnd_reg;
	logic refresh_ok;
	// R20 read then inverted write-back
	assign refresh_ok = spi_valid_in && rnd_read_reg && spi_word_in[15:8] == CMD_WD_REFRESH &&
		spi_word_in[7:0] == ~rnd_reg;
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rnd_read_reg <= 1'b0;
			rnd_reg <= 8'h00;
		end else if (spi_valid_in && spi_word_in == CMD_WD_READ) begin
			rnd_read_reg <= 1'b1;
			rnd_reg <= random_refresh_byte_in;
		end else if (spi_valid_in) begin
			rnd_read_reg <= 1'b0;
		end
	end

	logic [CNT_W-1:0] wd_cnt_reg;
	logic [3:0] wd_fail_reg;
	logic pulse_reg;
	logic [CNT_W-1:0] pulse_cnt_reg;
	logic wd_expire;
	logic wd_active;
	assign wd_active = state_reg != FSS_SAFE;
	assign wd_expire = wd_active && wd_cnt_reg == PERIOD_LAST && !refresh_ok;

	// R17 period counter
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in)
			wd_cnt_reg <= '0;
		else if (refresh_ok || !wd_active || wd_cnt_reg == PERIOD_LAST)
			wd_cnt_reg <= '0;
		else
			wd_cnt_reg <= wd_cnt_reg + 1'b1;
	end

	// R17 one millisecond pulse
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pulse_reg <= 1'b0;
			pulse_cnt_reg <= '0;
		end else if (wd_expire) begin
			pulse_reg <= 1'b1;
			pulse_cnt_reg <= '0;
		end else if (pulse_reg) begin
			pulse_cnt_reg <= pulse_cnt_reg + 1'b1;
			if (pulse_cnt_reg == PULSE_LAST)
				pulse_reg <= 1'b0;
		end
	end

	// R18 consecutive failure count
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in)
			wd_fail_reg <= 4'h0;
		else if (refresh_ok)
			wd_fail_reg <= 4'h0;
		else if (wd_expire && wd_fail_reg != FAIL_LIMIT)
			wd_fail_reg <= wd_fail_reg + 1'b1;
	end
	assign wd_fail8_out = wd_fail_reg == FAIL_LIMIT;

	// R14 first or second pulse
	logic wd_safe;
	assign wd_safe = wd_expire && (second_pulse_sel_in ? wd_fail_reg != 4'h0 : 1'b1);

	// ----------------------------------------------------------------
	// safe flags, clear and recovery
	// ----------------------------------------------------------------
	logic rst_stuck;
	logic set_safe;
	logic safe_flag_reg;
	logic clr_cmd;
	logic rst_drive;
	logic [1:0] drive_dly_reg;
	assign rst_drive = !rstn_out;
	// the sensed line lags our own drive by the two synchroniser stages; the drive is
	// delayed to match, otherwise every released reset would look clamped for two cycles
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in)
			drive_dly_reg <= 2'h3;
		else
			drive_dly_reg <= {drive_dly_reg[0], rst_drive};
	end
	// R16 reset line clamped low while not driven
	assign rst_stuck = !rst_pin && !rst_drive && drive_dly_reg == 2'h0;
	// R15 undervoltage with reset
	assign set_safe = wd_safe || wd_fail8_out || vdd_uv || rst_stuck;
	// R12 clear commands
	assign clr_cmd = spi_valid_in && (spi_word_in == CMD_SAFE_CLR0 || spi_word_in == CMD_SAFE_CLR1);
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in)
			safe_flag_reg <= 1'b0;
		else if (set_safe)
			safe_flag_reg <= 1'b1;
		else if (clr_cmd)
			safe_flag_reg <= 1'b0;
	end

	// ----------------------------------------------------------------
	// bus idle timer
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] idle_cnt_reg;
	logic idle_done;
	assign idle_done = idle_cnt_reg == IDLE_LAST;
	// R21 restart on activity
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in)
			idle_cnt_reg <= '0;
		else if (can_act || state_reg != FSS_SAFE)
			idle_cnt_reg <= '0;
		else if (!idle_done)
			idle_cnt_reg <= idle_cnt_reg + 1'b1;
	end

	// ----------------------------------------------------------------
	// mode state machine and supply
	// ----------------------------------------------------------------
	logic vdd_reg;
	logic off_cond;
	logic wake;
	logic recovered;
	always_comb begin
		unique case (safe_mode_reg)
			FSS_SAFE_A: off_cond = 1'b0;
			// R7 idle timeout
			FSS_SAFE_B1: off_cond = idle_done;
			// R8 low input
			FSS_SAFE_B2: off_cond = !in2;
			// R9 both together
			FSS_SAFE_B3: off_cond = idle_done && !in2;
		endcase
	end
	// R11 wake sources
	assign wake = can_act || lin_act || (pin_wake_reg && in2);
	// R19 recovery
	assign recovered = refresh_ok && rst_pin && !vdd_uv;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_reg <= FSS_INIT_RESET;
		end else begin
			unique case (state_reg)
				FSS_INIT_RESET: if (!pulse_reg && !vdd_uv) state_reg <= FSS_INIT;
				FSS_INIT: if (pulse_reg) state_reg <= FSS_INIT_RESET;
					else if (init_done_in) state_reg <= FSS_NORMAL;
				FSS_RESET: if (!pulse_reg && !vdd_uv) state_reg <= FSS_NORMAL_REQ;
				FSS_NORMAL_REQ: if (set_safe) state_reg <= FSS_SAFE;
					else if (pulse_reg) state_reg <= FSS_RESET;
					else if (refresh_ok) state_reg <= FSS_NORMAL;
				FSS_NORMAL: if (set_safe) state_reg <= FSS_SAFE;
					else if (pulse_reg) state_reg <= FSS_RESET;
				FSS_SAFE: begin
					// R10 wake enters reset
					if (!vdd_reg && wake)
						state_reg <= FSS_RESET;
					// R6 mode a leaves on recovery
					else if (vdd_reg && recovered)
						state_reg <= FSS_NORMAL;
				end
				default: state_reg <= FSS_INIT_RESET;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in)
			vdd_reg <= 1'b1;
		// R3 hold keeps on until power-on reset
		else if (hold_reg && por_s)
			vdd_reg <= 1'b0;
		// R2 off in reset when battery low
		else if (!hold_reg && !bat_ok && (state_reg == FSS_RESET || vdd_uv))
			vdd_reg <= 1'b0;
		else if (state_reg == FSS_SAFE && off_cond)
			vdd_reg <= 1'b0;
		else if (state_reg != FSS_SAFE && bat_ok)
			vdd_reg <= 1'b1;
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in)
			battery_fail_flag_out <= 1'b0;
		else if (por_s)
			battery_fail_flag_out <= 1'b1;
		else if (clr_cmd)
			battery_fail_flag_out <= 1'b0;
	end

	// R13 safe low in safe mode
	assign safen_out = !(safe_flag_reg || state_reg == FSS_SAFE);
	assign rstn_out = !(pulse_reg || vdd_uv || state_reg == FSS_RESET || state_reg == FSS_INIT_RESET);
	assign vdd_on_out = vdd_reg;
	assign state_out = state_reg;
	assign safe_mode_out = safe_mode_reg;

endmodule : fss_supervisor

/* File: verification/fss_props.sv */
// assertion checker for the fail-safe supply supervisor
`timescale 1ns/1ps
module fss_props #(
	parameter longint BUS_IDLE_CYC = 100
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic vdd_uv_in,
	input wire logic can_activity_in,
	input wire logic lin_activity_in,
	input wire logic gen_input2_in,
	input wire logic spi_valid_in,
	input wire logic [15:0] spi_word_in,
	input wire logic [2:0] safe_override_in,
	input wire logic override_write_in,
	input wire logic vdd_on_out,
	input wire logic rstn_out,
	input wire logic safen_out,
	input wire logic [5:0] state_out,
	input wire logic [1:0] safe_mode_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	// idle cycles in safe state; the design restarts later on synchronised activity, so only an upper bound is checked
	logic [7:0] idle_reg;
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in)
			idle_reg <= 8'h00;
		else if (can_activity_in || state_out != 6'h20)
			idle_reg <= 8'h00;
		else if (idle_reg != 8'hff)
			idle_reg <= idle_reg + 8'h01;
	end
	sequence s_pulse; !rstn_out [*4] ##1 rstn_out; endsequence
	sequence s_lin_wake; (state_out == 6'h20 && !vdd_on_out && lin_activity_in) [*3]; endsequence
	sequence s_in2_low; (state_out == 6'h20 && safe_mode_out == 2'h2 && !gen_input2_in) [*4]; endsequence
	property p_safe_low; state_out == 6'h20 |-> !safen_out; endproperty
	property p_uv; vdd_uv_in [*5] |-> !rstn_out && !safen_out; endproperty
	property p_pulse; $past(state_out) == 6'h10 && state_out == 6'h04 && !vdd_uv_in |-> s_pulse; endproperty
	property p_hold_safe; !safen_out && !(spi_valid_in && (spi_word_in == 16'hdd00 || spi_word_in == 16'hdd80))
		|=> !safen_out; endproperty
	property p_override; override_write_in && safe_override_in[2] |=> safe_mode_out == 2'(~$past(safe_override_in));
	endproperty
	property p_mode_a; state_out == 6'h20 && safe_mode_out == 2'h0 |-> vdd_on_out; endproperty
	property p_b1; state_out == 6'h20 && safe_mode_out == 2'h1 && idle_reg == 8'(BUS_IDLE_CYC + 8) |-> !vdd_on_out;
	endproperty
	property p_b2; s_in2_low |-> ##[0:3] !vdd_on_out; endproperty
	property p_wake; s_lin_wake |-> ##[0:4] state_out == 6'h04; endproperty
	a_safe_low: assert property (p_safe_low) else $error("safe output high in safe state");
	a_uv: assert property (p_uv) else $error("low supply without reset and safe");
	a_pulse: assert property (p_pulse) else $error("reset pulse length wrong");
	a_hold_safe: assert property (p_hold_safe) else $error("safe output released without clear");
	a_override: assert property (p_override) else $error("override code not applied");
	a_mode_a: assert property (p_mode_a) else $error("supply off in mode a");
	a_b1: assert property (p_b1) else $error("supply on after bus idle");
	a_b2: assert property (p_b2) else $error("supply on with input low");
	a_wake: assert property (p_wake) else $error("no reset after wake");
endmodule : fss_props
bind fss_supervisor fss_props #(.BUS_IDLE_CYC(BUS_IDLE_CYC)) i_props (.clk_in, .resetn_in, .vdd_uv_in,
	.can_activity_in, .lin_activity_in, .gen_input2_in, .spi_valid_in, .spi_word_in, .safe_override_in,
	.override_write_in, .vdd_on_out, .rstn_out, .safen_out, .state_out, .safe_mode_out);

/* File: verification/fss_host.sv */
// host controller model: spi command words and reset line echo
`timescale 1ns/1ps
module fss_host import fss_pkg::*; (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic stuck_in,
	input wire logic [7:0] rnd_in,
	output logic spi_valid_out,
	output logic [15:0] spi_word_out,
	output logic rst_pin_out
);
	// line echo
	// echo drops with the pulse start and rises at its end, a clamp holds the line low
	assign rst_pin_out = rstn_in & ~stuck_in;
	initial begin
		spi_valid_out = 1'b0;
		spi_word_out = 16'h0000;
	end
	task automatic send(input logic [15:0] word);
		@(posedge clk_in);
		#1;
		spi_valid_out = 1'b1;
		spi_word_out = word;
		@(posedge clk_in);
		#1;
		spi_valid_out = 1'b0;
		// idle word inverted so a stale value never reads as a command
		spi_word_out = ~word;
	endtask : send
	task automatic refresh;
		send(CMD_WD_READ);
		send({CMD_WD_REFRESH, ~rnd_in});
	endtask : refresh
endmodule : fss_host

/* File: verification/tb.sv */
// self-checking bench for the fail-safe supply supervisor
`timescale 1ns/1ps
module tb;
	import fss_pkg::*;
	logic clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic bat_ok = 1'b1, por = 1'b0, uv = 1'b0, can = 1'b0, lin = 1'b0, in2 = 1'b1, stuck = 1'b0;
	logic hold = 1'b0, hold_wr = 1'b0, ovr_wr = 1'b0, sel2 = 1'b0, wake_en = 1'b0;
	logic init_done = 1'b1, fail8;
	logic [2:0] dbg = 3'h6;
	logic [7:0] rnd = 8'h3c;
	logic spi_valid, rst_pin, vdd_on, rstn, safen, bfail;
	logic [2:0] ovr = 3'h7;
	logic [15:0] spi_word;
	logic [5:0] state;
	logic [1:0] mode;
	logic [2:0] row_code [5] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h3};
	logic [1:0] row_mode [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
	int error_cnt = 0;
	int n_tests = 0;
	int n;
	always #5 clk_in = ~clk_in;
	fss_supervisor #(.RST_PULSE_CYC(4), .WD_PERIOD_CYC(64), .BUS_IDLE_CYC(100)) i_dut (.clk_in, .resetn_in,
		.battery_supply_input_ok_in(bat_ok), .por_in(por), .vdd_uv_in(uv), .rst_pin_in(rst_pin),
		.can_activity_in(can), .lin_activity_in(lin), .gen_input2_in(in2), .debug_resistor_pin_in(dbg),
		.spi_valid_in(spi_valid), .spi_word_in(spi_word), .low_supply_hold_in(hold), .hold_write_in(hold_wr),
		.safe_override_in(ovr), .override_write_in(ovr_wr), .second_pulse_sel_in(sel2),
		.pin_wake_en_in(wake_en), .init_done_in(init_done), .random_refresh_byte_in(rnd), .vdd_on_out(vdd_on),
		.rstn_out(rstn), .safen_out(safen), .battery_fail_flag_out(bfail), .state_out(state),
		.safe_mode_out(mode), .wd_fail8_out(fail8));
	fss_host i_host (.clk_in, .rstn_in(rstn), .stuck_in(stuck), .rnd_in(rnd), .spi_valid_out(spi_valid),
		.spi_word_out(spi_word), .rst_pin_out(rst_pin));
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_in);
		#1;
	endtask : cyc
	task automatic tally_and_finish;
		if (error_cnt == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic ovr_set(input logic [2:0] code);
		ovr = code;
		ovr_wr = 1'b1;
		cyc(1);
		ovr_wr = 1'b0;
	endtask : ovr_set
	task automatic wait_rst(input logic lvl);
		for (n = 0; n < 100 && rstn !== lvl; n++)
			cyc(1);
		chk("rst wait", 8'(rstn), 8'(lvl));
	endtask : wait_rst
	task automatic wake_to_reset;
		for (n = 0; n < 20 && state !== 6'h04; n++)
			cyc(1);
		chk("wake", 8'(state), 8'h04);
	endtask : wake_to_reset
	task automatic recover(input logic [15:0] clr);
		stuck = 1'b0;
		uv = 1'b0;
		in2 = 1'b1;
		lin = 1'b0;
		can = 1'b0;
		cyc(4);
		// a write-back that is not inverted is refused
		i_host.send(CMD_WD_READ);
		i_host.send({CMD_WD_REFRESH, rnd});
		chk("bad refresh", 8'(state == 6'h10), 8'h00);
		i_host.refresh();
		i_host.send(clr);
		cyc(3);
		chk("released", 8'(safen), 8'h01);
		chk("normal", 8'(state), 8'h10);
	endtask : recover
	// bus-idle modes: supply holds until the idle timeout, input pin already low
	task automatic idle_case(input logic [2:0] code, input logic wen);
		ovr_set(code);
		wake_en = wen;
		in2 = 1'b0;
		stuck = 1'b1;
		cyc(6);
		stuck = 1'b0;
		cyc(30);
		// activity inside the safe state must restart the idle timer
		can = 1'b1;
		cyc(2);
		can = 1'b0;
		cyc(80);
		chk("idle early", 8'(vdd_on), 8'h01);
		cyc(40);
		chk("idle late", 8'(vdd_on), 8'h00);
	endtask : idle_case
	initial begin
		#100000;
		error_cnt++;
		tally_and_finish;
	end
	initial begin
		cyc(11);
		chk("rst state", 8'(state), 8'h01);
		chk("rst safe", 8'(safen), 8'h01);
		cyc(1);
		resetn_in = 1'b1;
		cyc(8);
		chk("state", 8'(state), 8'h10);
		chk("sampled", 8'(mode), 8'h01);
		foreach (row_code[k]) begin
			ovr_set(row_code[k]);
			cyc(1);
			chk("mode", 8'(mode), 8'(row_mode[k]));
		end
		ovr_set(3'h7);
		wait_rst(1'b0);
		wait_rst(1'b1);
		chk("pulse", 8'(n), 8'h04);
		chk("first", 8'(safen), 8'h00);
		recover(CMD_SAFE_CLR0);
		sel2 = 1'b1;
		wait_rst(1'b0);
		wait_rst(1'b1);
		cyc(2);
		chk("one pulse", 8'(safen), 8'h01);
		wait_rst(1'b0);
		wait_rst(1'b1);
		chk("second", 8'(safen), 8'h00);
		sel2 = 1'b0;
		recover(CMD_SAFE_CLR1);
		uv = 1'b1;
		cyc(5);
		chk("uv reset", 8'(rstn), 8'h00);
		chk("uv safe", 8'(safen), 8'h00);
		chk("uv supply", 8'(vdd_on), 8'h01);
		recover(CMD_SAFE_CLR0);
		stuck = 1'b1;
		cyc(6);
		chk("stuck", 8'(state), 8'h20);
		cyc(20);
		chk("mode a", 8'(vdd_on), 8'h01);
		recover(CMD_SAFE_CLR0);
		ovr_set(3'h5);
		stuck = 1'b1;
		cyc(6);
		stuck = 1'b0;
		in2 = 1'b0;
		cyc(6);
		chk("b2 off", 8'(vdd_on), 8'h00);
		in2 = 1'b1;
		cyc(6);
		chk("no pin wake", 8'(state), 8'h20);
		lin = 1'b1;
		wake_to_reset;
		recover(CMD_SAFE_CLR0);
		idle_case(3'h6, 1'b1);
		in2 = 1'b1;
		wake_to_reset;
		recover(CMD_SAFE_CLR1);
		idle_case(3'h4, 1'b0);
		can = 1'b1;
		wake_to_reset;
		recover(CMD_SAFE_CLR0);
		hold = 1'b1;
		hold_wr = 1'b1;
		cyc(1);
		hold_wr = 1'b0;
		uv = 1'b1;
		bat_ok = 1'b0;
		cyc(8);
		chk("held", 8'(vdd_on), 8'h01);
		por = 1'b1;
		cyc(6);
		chk("bat fail", 8'(bfail), 8'h01);
		chk("por off", 8'(vdd_on), 8'h00);
		resetn_in = 1'b0;
		por = 1'b0;
		uv = 1'b0;
		bat_ok = 1'b1;
		dbg = 3'h5;
		init_done = 1'b0;
		cyc(2);
		resetn_in = 1'b1;
		// held in init: pulses keep coming, eighth failure lands on cycle 512
		cyc(500);
		chk("seven fails", 8'(fail8), 8'h00);
		cyc(40);
		chk("eight fails", 8'(fail8), 8'h01);
		chk("init loop", 8'(state), 8'h02);
		init_done = 1'b1;
		cyc(4);
		chk("resampled", 8'(mode), 8'h02);
		chk("fail8 safe", 8'(state), 8'h20);
		uv = 1'b1;
		bat_ok = 1'b0;
		cyc(8);
		chk("off in reset", 8'(vdd_on), 8'h00);
		tally_and_finish;
	end
endmodule : tb
